/* hw/txm_top.sv */
// Transmit modulation control: register file, mode selection, keying
// Assumes APB master on pclk; data pin and packet inputs synchronous
//
// Implementation choice: the APB slave port.
`include "txm_regs.svh"

module txm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_data_pin,
    input  wire logic        tx_data_pin_driven,
    input  wire logic        packet_active,
    input  wire logic        packet_data,
    output logic             loop_enable,
    output logic             osc_mod_data,
    output logic             divider_select,
    output logic             carrier_on,
    output logic      [2:0]  pa_level,
    output logic      [2:0]  shaping_level,
    output txm_pkg::txm_mode_e active_mode
);
    import txm_pkg::*;

    // Software registers
    logic [7:0]  band_mode_ff;
    logic [7:0]  dev_att_ff;
    logic [7:0]  range_exp_ff;
    logic [7:0]  freq_div_ff;
    logic [7:0]  amp_ctrl_ff;
    logic [7:0]  amp_clk_ff;
    logic [7:0]  power_ff;

    // APB answer
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    // Bit-latched state
    txm_mode_e   mode_ff;
    logic        ask_run_ff;
    logic        data_bit_ff;

    // Output flops
    logic        loop_ff;
    logic        osc_ff;
    logic        div_ff;
    logic        carrier_ff;
    logic [2:0]  pa_ff;
    logic [2:0]  shape_ff;

    // Next values
    logic        nxt_loop;
    logic        nxt_osc;
    logic        nxt_div;
    logic        nxt_carrier;
    logic [2:0]  nxt_pa;
    logic [2:0]  nxt_shape;

    txm_tick_if  f_if ();
    txm_tick_if  a_if ();

    // Register fields and control terms derived from them
    txm_mode_e   mode_field;
    logic        ask_enable;
    logic        dither_sequence_select;
    logic [2:0]  amplitude_depth_code;
    logic [2:0]  amplitude_shaping_level;
    logic [2:0]  power_level_code;
    logic        ask_req;
    logic        bit_tick;
    logic        src_data;
    logic        dither_bit;
    logic        dither_run;
    logic        ook;
    logic        zero_sym;
    logic        host_drive;

    // Bus decode
    logic [7:0]  idx;
    logic        aligned;
    logic        setup;
    logic        wr_en;
    logic        hit_rw;
    logic        hit_ro;
    logic        bad;
    logic [7:0]  rd_byte;
    logic [7:0]  status;

    assign mode_field              = txm_mode_e'(band_mode_ff[`TXM_MODE_LSB +: 2]);
    assign ask_enable              = amp_ctrl_ff[`TXM_AMP_EN_BIT];
    assign dither_sequence_select  = amp_ctrl_ff[`TXM_DITHER_SEL_BIT];
    assign amplitude_depth_code    = amp_ctrl_ff[`TXM_DEPTH_LSB +: 3];
    assign amplitude_shaping_level = amp_ctrl_ff[`TXM_SHAPE_LSB +: 3];
    assign power_level_code        = power_ff[2:0];

    // Bit clocks
    assign f_if.divisor = freq_div_ff[5:0];
    assign f_if.shift   = 4'(range_exp_ff[`TXM_EXP_F_LSB +: 3]) + 4'(`TXM_FREQ_BASE_SH);
    assign a_if.divisor = amp_clk_ff[5:0];
    assign a_if.shift   = 4'(amp_clk_ff[`TXM_EXP_A_LSB +: 2]) + 4'(`TXM_AMP_BASE_SH);

    txm_bitclk u_fclk (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_if  (f_if)
    );

    txm_bitclk u_aclk (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_if  (a_if)
    );

    // dither runs only in spread keying
    assign dither_run = ask_run_ff && (mode_ff == TXM_DIVIDER);

    txm_dither u_dither (
        .pclk       (pclk),
        .presetn    (presetn),
        .chip_if    (f_if),
        .run        (dither_run),
        .seq_sel    (dither_sequence_select),
        .dither_bit (dither_bit)
    );

    // amplitude request, spread variant on mode two
    assign ask_req    = ask_enable && (mode_field == TXM_AMPLITUDE || mode_field == TXM_DIVIDER);
    // bits pace on the clock of the running mode
    assign bit_tick   = ask_run_ff ? a_if.tick : f_if.tick;
    assign host_drive = tx_data_pin_driven;
    assign src_data   = host_drive ? tx_data_pin : packet_data;

    // on-off keying when power at or below depth
    assign ook      = power_level_code <= amplitude_depth_code;
    assign zero_sym = ask_run_ff && !data_bit_ff;

    // loop opens only in open-loop frequency mode
    assign nxt_loop = !(mode_ff == TXM_OPEN && !ask_run_ff && (host_drive || packet_active));
    // oscillator modes carry the data bit
    assign nxt_osc  = !ask_run_ff && (mode_ff == TXM_CLOSED || mode_ff == TXM_OPEN) && data_bit_ff;
    // divider select from data or dither
    assign nxt_div  = (mode_ff == TXM_DIVIDER) && (ask_run_ff ? dither_bit : data_bit_ff);
    // zero symbol level is the depth code, carrier off under on-off keying
    assign nxt_carrier = !(zero_sym && ook);
    assign nxt_pa      = !zero_sym ? power_level_code : (ook ? 3'h0 : amplitude_depth_code);
    // shaping applied only while keying amplitude
    assign nxt_shape   = ask_run_ff ? amplitude_shaping_level : 3'h0;

    // Bit boundary latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff     <= TXM_CLOSED;
            ask_run_ff  <= 1'b0;
            data_bit_ff <= 1'b0;
        end else if (bit_tick) begin
            mode_ff     <= mode_field;
            ask_run_ff  <= ask_req;
            data_bit_ff <= src_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_ff    <= 1'b1;
            osc_ff     <= 1'b0;
            div_ff     <= 1'b0;
            carrier_ff <= 1'b1;
            pa_ff      <= 3'h0;
            shape_ff   <= 3'h0;
        end else begin
            loop_ff    <= nxt_loop;
            osc_ff     <= nxt_osc;
            div_ff     <= nxt_div;
            carrier_ff <= nxt_carrier;
            pa_ff      <= nxt_pa;
            shape_ff   <= nxt_shape;
        end
    end

    // APB slave, no wait states
    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign hit_rw  = aligned && (idx == `TXM_IDX_BAND_MODE || idx == `TXM_IDX_DEV_ATT
                   || idx == `TXM_IDX_RANGE_EXP || idx == `TXM_IDX_FREQ_DIV
                   || idx == `TXM_IDX_AMP_CTRL || idx == `TXM_IDX_AMP_CLK
                   || idx == `TXM_IDX_POWER);
    assign hit_ro  = aligned && idx == `TXM_IDX_STATUS;
    assign bad     = !(hit_rw || (hit_ro && !pwrite));
    assign status  = {2'b00, data_bit_ff, ask_run_ff, carrier_ff, loop_ff, 2'(mode_ff)};

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            `TXM_IDX_BAND_MODE: rd_byte = band_mode_ff;
            `TXM_IDX_DEV_ATT:   rd_byte = dev_att_ff;
            `TXM_IDX_RANGE_EXP: rd_byte = range_exp_ff;
            `TXM_IDX_FREQ_DIV:  rd_byte = freq_div_ff;
            `TXM_IDX_AMP_CTRL:  rd_byte = amp_ctrl_ff;
            `TXM_IDX_AMP_CLK:   rd_byte = amp_clk_ff;
            `TXM_IDX_POWER:     rd_byte = {5'h00, power_ff[2:0]};
            `TXM_IDX_STATUS:    rd_byte = status;
            default:            rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && bad;
            if (setup) begin
                prdata_ff <= (aligned && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            band_mode_ff <= `TXM_RST_REG;
            dev_att_ff   <= `TXM_RST_REG;
            range_exp_ff <= `TXM_RST_REG;
            freq_div_ff  <= `TXM_RST_REG;
            amp_ctrl_ff  <= `TXM_RST_REG;
            amp_clk_ff   <= `TXM_RST_REG;
            power_ff     <= `TXM_RST_REG;
        end else if (wr_en) begin
            if (idx == `TXM_IDX_BAND_MODE) band_mode_ff <= pwdata[7:0];
            if (idx == `TXM_IDX_DEV_ATT)   dev_att_ff   <= pwdata[7:0];
            if (idx == `TXM_IDX_RANGE_EXP) range_exp_ff <= pwdata[7:0];
            if (idx == `TXM_IDX_FREQ_DIV)  freq_div_ff  <= pwdata[7:0];
            if (idx == `TXM_IDX_AMP_CTRL)  amp_ctrl_ff  <= pwdata[7:0];
            if (idx == `TXM_IDX_AMP_CLK)   amp_clk_ff   <= pwdata[7:0];
            if (idx == `TXM_IDX_POWER)     power_ff     <= {5'h00, pwdata[2:0]};
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign loop_enable    = loop_ff;
    assign osc_mod_data   = osc_ff;
    assign divider_select = div_ff;
    assign carrier_on     = carrier_ff;
    assign pa_level       = pa_ff;
    assign shaping_level  = shape_ff;
    assign active_mode    = mode_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_closed_loop_on : assert property (
        mode_ff == TXM_CLOSED && !ask_run_ff ##1 mode_ff == TXM_CLOSED |-> loop_enable)
        else $error("loop opened in closed-loop mode");

    a_osc_data : assert property (
        !ask_run_ff && mode_ff inside {TXM_CLOSED, TXM_OPEN} |=> osc_mod_data == $past(data_bit_ff))
        else $error("oscillator data does not follow bit");

    a_open_pin_drive : assert property (
        mode_ff == TXM_OPEN && !ask_run_ff && tx_data_pin_driven |=> !loop_enable)
        else $error("loop not opened while pin driven");

    a_open_packet : assert property (
        mode_ff == TXM_OPEN && !ask_run_ff && !tx_data_pin_driven
        |=> loop_enable == !$past(packet_active))
        else $error("loop state wrong around packet");

    a_divider_bit : assert property (
        mode_ff == TXM_DIVIDER && !ask_run_ff |=> divider_select == $past(data_bit_ff))
        else $error("divider set does not follow bit");

    a_keying_gate : assert property (
        !ask_run_ff |=> carrier_on && pa_level == $past(power_level_code) && shaping_level == 3'h0)
        else $error("amplitude keyed while keying off");

    a_zero_depth : assert property (
        zero_sym && !ook |=> carrier_on && pa_level == $past(amplitude_depth_code))
        else $error("zero symbol level wrong");

    a_ook_off : assert property (
        zero_sym && ook |=> !carrier_on)
        else $error("carrier present on on-off zero");

    a_shape_level : assert property (
        ask_run_ff |=> shaping_level == $past(amplitude_shaping_level))
        else $error("shaping code not applied");

    a_spread_dither : assert property (
        dither_run |=> divider_select == $past(dither_bit))
        else $error("divider not following dither");

    a_mode_hold : assert property (
        !bit_tick |=> $stable(mode_ff) && $stable(ask_run_ff) && $stable(data_bit_ff))
        else $error("mode changed inside a bit");

    c_open_packet : cover property (mode_ff == TXM_OPEN && packet_active ##1 !loop_enable);
    c_ook_zero    : cover property (zero_sym && ook ##1 !carrier_on);
    c_spread_run  : cover property (dither_run && dither_sequence_select ##1 divider_select);

endmodule : txm_top

/* shared/txm_regs.svh */
// Register indices, field positions, reset values and timing bases
// Byte address of each register is four times its index
`ifndef TXM_REGS_SVH
`define TXM_REGS_SVH

`define TXM_IDX_BAND_MODE   8'h0b
`define TXM_IDX_DEV_ATT     8'h0e
`define TXM_IDX_RANGE_EXP   8'h0f
`define TXM_IDX_FREQ_DIV    8'h10
`define TXM_IDX_AMP_CTRL    8'h11
`define TXM_IDX_AMP_CLK     8'h12
`define TXM_IDX_POWER       8'h18
`define TXM_IDX_STATUS      8'h19

`define TXM_MODE_LSB        0
`define TXM_EXP_F_LSB       3
`define TXM_DEPTH_LSB       0
`define TXM_SHAPE_LSB       3
`define TXM_AMP_EN_BIT      6
`define TXM_DITHER_SEL_BIT  7
`define TXM_EXP_A_LSB       6

`define TXM_RST_REG         8'h00
`define TXM_FREQ_BASE_SH    3
`define TXM_AMP_BASE_SH     5
`define TXM_PN_LEN          15
`define TXM_PN_SEQ          15'h7ac8

`endif

/* shared/txm_pkg.sv */
// Types shared by the modulation control modules
// Assumes the register header is included where offsets are needed
package txm_pkg;

    typedef enum logic [1:0] {
        TXM_CLOSED,
        TXM_OPEN,
        TXM_DIVIDER,
        TXM_AMPLITUDE
    } txm_mode_e;

    typedef logic [16:0] txm_period_t;

    // Cycles per bit: divisor times two to the shift, zero divisor as one
    function automatic txm_period_t txm_period(input logic [5:0] k,
                                               input logic [3:0] sh);
        logic [5:0] kk;
        kk = (k == 6'h00) ? 6'h01 : k;
        return txm_period_t'({11'h000, kk} << sh);
    endfunction : txm_period

endpackage : txm_pkg

/* shared/txm_tick_if.sv */
// Bit clock settings and tick between the control core and its helpers
// Assumes one clock domain, pclk
interface txm_tick_if;
    logic [5:0] divisor;
    logic [3:0] shift;
    logic       tick;

    modport gen (input divisor, input shift, output tick);
    modport use_tick (input tick);
endinterface : txm_tick_if

/* hw/txm_bitclk.sv */
// Bit clock divider: one tick every divisor times 2^shift cycles
// Assumes settings written by software, held stable between bits
module txm_bitclk (
    input  wire logic  pclk,
    input  wire logic  presetn,
    txm_tick_if.gen    clk_if
);
    import txm_pkg::*;

    txm_period_t cnt_ff;
    txm_period_t nxt_cnt;
    logic        tick_ff;
    logic        wrap;

    assign wrap    = cnt_ff >= (txm_period(clk_if.divisor, clk_if.shift) - 17'h0_0001);
    assign nxt_cnt = wrap ? 17'h0_0000 : cnt_ff + 17'h0_0001;
    assign clk_if.tick = tick_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 17'h0_0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= wrap;
        end
    end

    a_tick_single : assert property (@(posedge pclk) disable iff (!presetn)
        tick_ff |=> !tick_ff || (txm_period(clk_if.divisor, clk_if.shift) == 17'h0_0001))
        else $error("bit clock tick lasted two cycles");

endmodule : txm_bitclk

/* hw/txm_dither.sv */
// Dither bit source for spread amplitude keying
// Assumes one tick per dither chip from the frequency bit clock
`include "txm_regs.svh"
module txm_dither (
    input  wire logic  pclk,
    input  wire logic  presetn,
    txm_tick_if.use_tick chip_if,
    input  wire logic  run,
    input  wire logic  seq_sel,
    output logic       dither_bit
);
    import txm_pkg::*;

    localparam logic [14:0] SEQ = `TXM_PN_SEQ;

    logic [3:0] idx_ff;
    logic       bit_ff;
    logic [3:0] nxt_idx;
    logic       nxt_bit;

    assign nxt_idx = (idx_ff == 4'(`TXM_PN_LEN - 1)) ? 4'h0 : idx_ff + 4'h1;
    assign nxt_bit = seq_sel ? SEQ[4'(`TXM_PN_LEN - 1) - idx_ff] : ~bit_ff;
    assign dither_bit = bit_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_ff <= 4'h0;
            bit_ff <= 1'b0;
        end else if (!run) begin
            idx_ff <= 4'h0;
            bit_ff <= 1'b0;
        end else if (chip_if.tick) begin
            idx_ff <= seq_sel ? nxt_idx : 4'h0;
            bit_ff <= nxt_bit;
        end
    end

    a_alt_pattern : assert property (@(posedge pclk) disable iff (!presetn)
        run && chip_if.tick && !seq_sel |=> run -> (bit_ff != $past(bit_ff)))
        else $error("alternating dither did not toggle");

    a_seq_pattern : assert property (@(posedge pclk) disable iff (!presetn)
        run && chip_if.tick && seq_sel |=> run -> (bit_ff == SEQ[4'd14 - $past(idx_ff)]))
        else $error("dither sequence bit wrong");

    c_seq_wrap : cover property (@(posedge pclk) disable iff (!presetn)
        run && seq_sel && chip_if.tick && idx_ff == 4'd14);

endmodule : txm_dither

/* tb/txm_host_model.sv */
// Host model: drives the transmit data pin or a packet stream
// Assumes pclk from the bench; inputs change right after a rising edge
module txm_host_model (
    input  wire logic       pclk,
    input  wire logic [1:0] how,
    input  wire logic       bit_val,
    output logic            tx_data_pin,
    output logic            tx_data_pin_driven,
    output logic            packet_active,
    output logic            packet_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tx_data_pin        = 1'b0;
        tx_data_pin_driven = 1'b0;
        packet_active      = 1'b0;
        packet_data        = 1'b0;
    end

    // Undriven lines toggle so stale levels never look valid
    always @(posedge pclk) begin
        tx_data_pin_driven <= (how == 2'd1);
        tx_data_pin        <= (how == 2'd1) ? bit_val : ~tx_data_pin;
        packet_active      <= (how == 2'd2);
        packet_data        <= (how == 2'd2) ? bit_val : ~packet_data;
    end
endmodule : txm_host_model

/* tb/tx_modulation_control_tb.sv */
// Self-checking bench for the transmit modulation control block
// Assumes the register header and package compiled before this file
`include "txm_regs.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

module tx_modulation_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import txm_pkg::*;

    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        pin_drv;
    logic        pkt_act;
    logic        pkt_dat;
    logic        loop_enable;
    logic        osc_mod_data;
    logic        divider_select;
    logic        carrier_on;
    logic [2:0]  pa_level;
    logic [2:0]  shaping_level;
    txm_mode_e   active_mode;
    logic [1:0]  how;
    logic        bit_val;
    int          fails;
    int          tests_run;
    int          cycles;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  idx_tab [6];

    txm_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
                 .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                 .tx_data_pin(pin), .tx_data_pin_driven(pin_drv), .packet_active(pkt_act),
                 .packet_data(pkt_dat), .loop_enable(loop_enable), .osc_mod_data(osc_mod_data),
                 .divider_select(divider_select), .carrier_on(carrier_on), .pa_level(pa_level),
                 .shaping_level(shaping_level), .active_mode(active_mode));

    txm_host_model host (.pclk(pclk), .how(how), .bit_val(bit_val), .tx_data_pin(pin),
                         .tx_data_pin_driven(pin_drv), .packet_active(pkt_act), .packet_data(pkt_dat));

    always #5 pclk = ~pclk;

    task automatic summarize;
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            summarize();
        end
    end

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // No limit of its own; the bench timeout ends this wait if pready never rises
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    // Samples one divider choice per chip and seeks a rotation of the pattern
    task automatic spread_check(input logic [14:0] pat, input int p);
        logic s [30];
        logic hit;
        logic ok;
        for (int i = 0; i < 30; i++) begin
            cyc(8);
            s[i] = divider_select;
        end
        hit = 1'b0;
        for (int r = 0; r < p; r++) begin
            ok = 1'b1;
            for (int i = 0; i < 30; i++) begin
                if (s[i] !== pat[p - 1 - ((i + r) % p)]) ok = 1'b0;
            end
            if (ok) hit = 1'b1;
        end
        `CHK(hit, 1'b1)
    endtask : spread_check

    initial begin
        pclk = 1'b0; presetn = 1'b0; paddr = 12'h000; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; pwdata = 32'h0000_0000; how = 2'd0; bit_val = 1'b0;
        fails = 0; tests_run = 0; cycles = 0;
        idx_tab = '{`TXM_IDX_BAND_MODE, `TXM_IDX_DEV_ATT, `TXM_IDX_RANGE_EXP,
                    `TXM_IDX_FREQ_DIV, `TXM_IDX_AMP_CTRL, `TXM_IDX_AMP_CLK};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, read-back, unmapped and read-only places
        foreach (idx_tab[i]) begin
            apb(1'b0, idx_tab[i], 8'h00);
            `CHK(rd, 32'h0000_0000)
            apb(1'b1, idx_tab[i], 8'ha5 ^ 8'(i));
            apb(1'b0, idx_tab[i], 8'h00);
            `CHK(rd, {24'h00_0000, 8'ha5 ^ 8'(i)})
            apb(1'b1, idx_tab[i], 8'h00);
        end
        apb(1'b0, 8'h20, 8'h00);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, `TXM_IDX_STATUS, 8'hff);
        `CHK(err, 1'b1)
        // exponents kept in range; dither faster than keying
        apb(1'b1, `TXM_IDX_FREQ_DIV, 8'h01);
        apb(1'b1, `TXM_IDX_AMP_CLK, 8'h01);
        how <= 2'd1;
        bit_val <= 1'b1;
        cyc(30);
        `CHK({loop_enable, osc_mod_data, divider_select, active_mode}, {3'b110, TXM_CLOSED})
        // closed-loop data kept balanced: a one, then a zero
        bit_val <= 1'b0;
        cyc(30);
        `CHK({loop_enable, osc_mod_data, active_mode}, {2'b10, TXM_CLOSED})
        how <= 2'd0;
        apb(1'b1, `TXM_IDX_BAND_MODE, 8'h01);
        cyc(30);
        `CHK({loop_enable, active_mode}, {1'b1, TXM_OPEN})
        how <= 2'd1;
        bit_val <= 1'b0;
        cyc(30);
        `CHK({loop_enable, osc_mod_data}, 2'b00)
        bit_val <= 1'b1;
        cyc(30);
        `CHK({loop_enable, osc_mod_data}, 2'b01)
        how <= 2'd2;
        cyc(30);
        `CHK({loop_enable, osc_mod_data}, 2'b01)
        how <= 2'd0;
        cyc(5);
        `CHK(loop_enable, 1'b1)
        // mode change waits for the bit boundary
        apb(1'b1, `TXM_IDX_FREQ_DIV, 8'h3f);
        how <= 2'd1;
        bit_val <= 1'b0;
        cyc(600);
        bit_val <= 1'b1;
        for (int i = 0; i < 600 && osc_mod_data !== 1'b1; i++) cyc(1);
        `CHK(osc_mod_data, 1'b1)
        apb(1'b1, `TXM_IDX_BAND_MODE, 8'h02);
        cyc(1);
        `CHK(active_mode, TXM_OPEN)
        cyc(520);
        `CHK(active_mode, TXM_DIVIDER)
        apb(1'b1, `TXM_IDX_FREQ_DIV, 8'h01);
        cyc(30);
        `CHK({divider_select, osc_mod_data}, 2'b10)
        bit_val <= 1'b0;
        cyc(30);
        `CHK(divider_select, 1'b0)
        // loop filter and phase margin choices sit outside this block
        apb(1'b1, `TXM_IDX_POWER, 8'h05);
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'h7a);
        apb(1'b1, `TXM_IDX_BAND_MODE, 8'h03);
        bit_val <= 1'b1;
        cyc(100);
        `CHK({carrier_on, pa_level, shaping_level, active_mode}, {1'b1, 3'd5, 3'd7, TXM_AMPLITUDE})
        bit_val <= 1'b0;
        cyc(100);
        `CHK({carrier_on, pa_level}, {1'b1, 3'd2})
        apb(1'b1, `TXM_IDX_POWER, 8'h02);
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'h7b);
        cyc(100);
        `CHK({carrier_on, pa_level, shaping_level}, {1'b0, 3'd0, 3'd7})
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'h3b);
        cyc(100);
        `CHK({carrier_on, shaping_level}, {1'b1, 3'd0})
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'h5b);
        cyc(100);
        `CHK(shaping_level, 3'd3)
        // spread keying dithers the divider set
        apb(1'b1, `TXM_IDX_POWER, 8'h05);
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'hc2);
        apb(1'b1, `TXM_IDX_BAND_MODE, 8'h02);
        bit_val <= 1'b1;
        cyc(80);
        spread_check(15'h7ac8, 15);
        apb(1'b1, `TXM_IDX_AMP_CTRL, 8'h42);
        cyc(80);
        spread_check(15'h0002, 2);
        // Status: data one, keying on, carrier on, loop on, mode two
        apb(1'b0, `TXM_IDX_STATUS, 8'h00);
        `CHK({err, rd}, {1'b0, 32'h0000_003e})
        apb(1'b0, `TXM_IDX_POWER, 8'h00);
        `CHK({err, rd}, {1'b0, 32'h0000_0005})
        summarize();
    end
endmodule : tx_modulation_control_tb
